// file: verilog/tsic_regs.vh
// register map, field positions and constants of the three-source irq control
`ifndef TSIC_REGS_VH
`define TSIC_REGS_VH

// register indices; byte address is four times the index
`define TSIC_IDX_CONTROL 6'h0B
`define TSIC_IDX_EVENTS 6'h0C
`define TSIC_IDX_EVMASK 6'h0D
`define TSIC_IDX_STACK 6'h0E

// address split: word index above the byte offset
`define TSIC_ADDR_IDX_MSB 7
`define TSIC_ADDR_IDX_LSB 2

// control register fields
`define TSIC_BIT_GIE 0
`define TSIC_BIT_TICK_EN 1
`define TSIC_BIT_TA_EN 2
`define TSIC_BIT_TB_EN 3
`define TSIC_BIT_TICK_PEND 4
`define TSIC_BIT_TA_PEND 5
`define TSIC_BIT_TB_PEND 6
`define TSIC_CONTROL_LIVE_MSB 6
`define TSIC_CONTROL_RESET 8'h00

// event status / mask fields
`define TSIC_EV_ACK 0
`define TSIC_EV_REFUSED 1
`define TSIC_EV_OVERFLOW 2
`define TSIC_EV_W 3
`define TSIC_EV_RESET 3'h0

// stack status fields
`define TSIC_STK_FULL_BIT 3

// service vectors
`define TSIC_VEC_TICK 11'h004
`define TSIC_VEC_TA 11'h008
`define TSIC_VEC_TB 11'h00C
`define TSIC_PC_RESET 11'h000

`define TSIC_STACK_DEPTH 4
`define TSIC_PC_W 11

`endif

// file: verilog/tsic_stack.v
// four-level return stack for program counter values
`timescale 1ns/1ns
`default_nettype none
module tsic_stack #(
	parameter DEPTH = 4,
	parameter W = 11,
	parameter CNT_W = 3
) (
	input wire pclk, // clock
	input wire presetn, // async reset, active low
	input wire push, // push din
	input wire pop, // pop top entry
	input wire [W-1:0] din, // value to push
	output wire [W-1:0] top, // current top entry
	output reg [CNT_W-1:0] count_reg, // occupied entries
	output wire full // all entries occupied
);
	reg [W-1:0] ent_reg [0:DEPTH-1];
	integer i;

	assign top = ent_reg[0];
	assign full = (count_reg == DEPTH[CNT_W-1:0]);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				ent_reg[i] <= {W{1'b0}};
			end
			count_reg <= {CNT_W{1'b0}};
		end else if (push && !pop) begin
			// push on a full stack drops the oldest entry
			for (i = DEPTH - 1; i > 0; i = i - 1) begin
				ent_reg[i] <= ent_reg[i-1];
			end
			ent_reg[0] <= din;
			if (!full) begin
				count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end else if (pop && !push) begin
			for (i = 0; i < DEPTH - 1; i = i + 1) begin
				ent_reg[i] <= ent_reg[i+1];
			end
			ent_reg[DEPTH-1] <= {W{1'b0}};
			if (count_reg != {CNT_W{1'b0}}) begin
				count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end else if (push && pop) begin
			// replace top: net depth unchanged
			ent_reg[0] <= din;
		end
	end
endmodule // tsic_stack
`default_nettype wire

// file: verilog/tsic_irq_ctrl.v
// three-source interrupt control with return stack and APB registers
`timescale 1ns/1ns
`default_nettype none
`include "tsic_regs.vh"
module tsic_irq_ctrl #(
	parameter ADDR_W = 8,
	parameter PC_W = `TSIC_PC_W,
	parameter DEPTH = `TSIC_STACK_DEPTH,
	parameter CNT_W = 3
) (
	input wire pclk, // instruction clock
	input wire presetn, // async reset, active low
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB direction, 1 = write
	input wire [ADDR_W-1:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	input wire [3:0] pstrb, // APB byte strobes
	output reg [31:0] prdata_reg, // APB read data
	output reg pready_reg, // APB ready
	output reg pslverr_reg, // APB error
	input wire second_clock_phase, // sampling pulse, one every four clocks
	input wire tick_event, // time base event pulse
	input wire timer_a_ovf, // timer A overflow pulse
	input wire timer_b_ovf, // timer B overflow pulse
	input wire call_req, // CPU subroutine call pulse
	input wire subroutine_return, // plain return pulse
	input wire return_and_unmask, // return that re-enables pulse
	input wire [PC_W-1:0] pc_in, // program counter to save
	output reg ack_valid_reg, // vectored call pulse
	output reg [PC_W-1:0] vector_reg, // call target
	output reg ret_valid_reg, // popped address pulse
	output reg [PC_W-1:0] ret_pc_reg, // popped address
	output reg global_irq_enable_reg, // global enable state
	output reg irq_reg // event interrupt, level
);
	localparam ST_IDLE = 1'b0;
	localparam ST_DONE = 1'b1;

	reg state_reg;
	reg state_next;
	reg [7:0] control_reg;
	reg [7:0] control_next;
	reg [`TSIC_EV_W-1:0] events_reg;
	reg [`TSIC_EV_W-1:0] events_next;
	reg [`TSIC_EV_W-1:0] evmask_reg;
	reg [PC_W-1:0] vec_sel;
	reg [31:0] rd_mux;
	reg rd_hit;

	wire [CNT_W-1:0] stk_count;
	wire [PC_W-1:0] stk_top;
	wire stk_full;
	wire [5:0] idx;
	wire aligned;
	wire setup_seen;
	wire complete;
	wire wr_do;
	wire rd_do;
	wire lane0;
	wire pop_any;
	wire gie;
	wire req_tick;
	wire req_ta;
	wire req_tb;
	wire any_req;
	wire ack;
	wire refused;
	wire push;
	wire wr_ctrl;
	wire wr_mask;
	wire rd_events;
	wire grant_tick;
	wire grant_ta;
	wire grant_tb;

	assign idx = paddr[`TSIC_ADDR_IDX_MSB:`TSIC_ADDR_IDX_LSB];
	assign aligned = (paddr[`TSIC_ADDR_IDX_LSB-1:0] == 2'b00);
	assign setup_seen = psel & penable & (state_reg == ST_IDLE);
	assign complete = psel & penable & pready_reg;
	assign wr_do = complete & pwrite & ~pslverr_reg;
	assign rd_do = complete & ~pwrite & ~pslverr_reg;
	assign lane0 = pstrb[0];
	// byte lane 0 carries every 8-bit register
	assign wr_ctrl = wr_do & (idx == `TSIC_IDX_CONTROL) & lane0;
	assign wr_mask = wr_do & (idx == `TSIC_IDX_EVMASK) & lane0;
	assign rd_events = rd_do & (idx == `TSIC_IDX_EVENTS);

	assign pop_any = subroutine_return | return_and_unmask;
	assign gie = control_reg[`TSIC_BIT_GIE];
	assign req_tick = control_reg[`TSIC_BIT_TICK_PEND] &
		control_reg[`TSIC_BIT_TICK_EN];
	assign req_ta = control_reg[`TSIC_BIT_TA_PEND] &
		control_reg[`TSIC_BIT_TA_EN];
	assign req_tb = control_reg[`TSIC_BIT_TB_PEND] &
		control_reg[`TSIC_BIT_TB_EN];
	assign any_req = gie & (req_tick | req_ta | req_tb);
	// hold off while full
	// a pop in the same cycle frees a level only at the next pulse
	assign ack = second_clock_phase & any_req & ~stk_full & ~pop_any;
	assign refused = second_clock_phase & any_req & stk_full;
	assign push = ack | call_req;

	tsic_stack #(
		.DEPTH(DEPTH),
		.W(PC_W),
		.CNT_W(CNT_W)
	) u_stack (
		.pclk(pclk),
		.presetn(presetn),
		.push(push),
		.pop(pop_any),
		.din(pc_in),
		.top(stk_top),
		.count_reg(stk_count),
		.full(stk_full)
	);

	// tick, then A, then B
	// one encoder feeds both the vector and the flag clear,
	// so the call target and the cleared flag always agree
	assign grant_tick = req_tick;
	assign grant_ta = req_ta & ~req_tick;
	assign grant_tb = req_tb & ~req_tick & ~req_ta;

	always @* begin
		if (grant_tick) begin
			vec_sel = `TSIC_VEC_TICK;
		end else if (grant_ta) begin
			vec_sel = `TSIC_VEC_TA;
		end else begin
			vec_sel = `TSIC_VEC_TB;
		end
	end

	// control register next value; hardware sets win over clears
	always @* begin
		control_next = control_reg;
		if (wr_ctrl) begin
			control_next = {1'b0, pwdata[`TSIC_CONTROL_LIVE_MSB:0]};
		end
		if (ack) begin
			control_next[`TSIC_BIT_GIE] = 1'b0;
			if (grant_tick) begin
				control_next[`TSIC_BIT_TICK_PEND] = 1'b0;
			end
			if (grant_ta) begin
				control_next[`TSIC_BIT_TA_PEND] = 1'b0;
			end
			if (grant_tb) begin
				control_next[`TSIC_BIT_TB_PEND] = 1'b0;
			end
		end
		if (return_and_unmask) begin
			control_next[`TSIC_BIT_GIE] = 1'b1;
		end
		if (tick_event) begin
			control_next[`TSIC_BIT_TICK_PEND] = 1'b1;
		end
		if (timer_a_ovf) begin
			control_next[`TSIC_BIT_TA_PEND] = 1'b1;
		end
		if (timer_b_ovf) begin
			control_next[`TSIC_BIT_TB_PEND] = 1'b1;
		end
	end

	// sticky events; a read clears only the bits it returned
	always @* begin
		events_next = events_reg;
		if (rd_events) begin
			events_next = events_reg & ~prdata_reg[`TSIC_EV_W-1:0];
		end
		if (ack) begin
			events_next[`TSIC_EV_ACK] = 1'b1;
		end
		if (refused) begin
			events_next[`TSIC_EV_REFUSED] = 1'b1;
		end
		if (call_req && stk_full && !pop_any) begin
			events_next[`TSIC_EV_OVERFLOW] = 1'b1;
		end
	end

	always @* begin
		rd_mux = 32'h00000000;
		rd_hit = aligned;
		case (idx)
		`TSIC_IDX_CONTROL: begin
			rd_mux[7:0] = control_reg;
		end
		`TSIC_IDX_EVENTS: begin
			rd_mux[`TSIC_EV_W-1:0] = events_reg;
		end
		`TSIC_IDX_EVMASK: begin
			rd_mux[`TSIC_EV_W-1:0] = evmask_reg;
		end
		`TSIC_IDX_STACK: begin
			rd_mux[CNT_W-1:0] = stk_count;
			rd_mux[`TSIC_STK_FULL_BIT] = stk_full;
		end
		default: begin
			rd_hit = 1'b0;
		end
		endcase
	end

	// one wait state: ready rises the cycle after the access phase starts
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (setup_seen) begin
				state_next = ST_DONE;
			end
		end
		ST_DONE: begin
			state_next = ST_IDLE;
		end
		default: begin
			state_next = ST_IDLE;
		end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			pready_reg <= setup_seen;
			if (setup_seen) begin
				pslverr_reg <= ~rd_hit |
					(pwrite && idx == `TSIC_IDX_STACK);
				prdata_reg <= (pwrite || !rd_hit) ? 32'h00000000 : rd_mux;
			end else if (complete) begin
				pslverr_reg <= 1'b0;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= `TSIC_CONTROL_RESET;
			global_irq_enable_reg <= 1'b0;
		end else begin
			control_reg <= control_next;
			global_irq_enable_reg <= control_next[`TSIC_BIT_GIE];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			events_reg <= `TSIC_EV_RESET;
		end else begin
			events_reg <= events_next;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evmask_reg <= `TSIC_EV_RESET;
		end else if (wr_mask) begin
			evmask_reg <= pwdata[`TSIC_EV_W-1:0];
		end
	end

	// follows new events at once; a mask write counts a cycle later
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(events_next & evmask_reg);
		end
	end

	// vectored call and return outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_valid_reg <= 1'b0;
			vector_reg <= `TSIC_PC_RESET;
			ret_valid_reg <= 1'b0;
			ret_pc_reg <= `TSIC_PC_RESET;
		end else begin
			ack_valid_reg <= ack;
			if (ack) begin
				vector_reg <= vec_sel;
			end
			ret_valid_reg <= pop_any;
			if (pop_any) begin
				ret_pc_reg <= stk_top;
			end
		end
	end
endmodule // tsic_irq_ctrl
`default_nettype wire

// file: test/tsic_chk.sv
// concurrent checks on the irq control ports
`timescale 1ns/1ns
`default_nettype none
module tsic_chk (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pready_reg, // apb ready
	input wire logic second_clock_phase, // sampling pulse
	input wire logic subroutine_return, // plain return
	input wire logic return_and_unmask, // unmasking return
	input wire logic ack_valid_reg, // vectored call
	input wire logic [10:0] vector_reg, // call target
	input wire logic ret_valid_reg, // popped pulse
	input wire logic global_irq_enable_reg // global enable
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_access;
		psel && !penable ##1 psel && penable;
	endsequence
	// software write in the same cycle may also move the enable
	sequence plain_ret;
		subroutine_return && !return_and_unmask && !pready_reg;
	endsequence
	apb_wait_a: assert property (apb_access |=> pready_reg)
		else $error("apb ready not after one wait");
	ready_pulse_a: assert property (pready_reg |=> !pready_reg)
		else $error("apb ready longer than a cycle");
	ack_masks_a: assert property (ack_valid_reg |-> !global_irq_enable_reg)
		else $error("global enable left set on call");
	ack_single_a: assert property (ack_valid_reg |=> !ack_valid_reg)
		else $error("two calls back to back");
	ack_sampled_a: assert property (ack_valid_reg |-> $past(second_clock_phase))
		else $error("call not on sampling pulse");
	ack_gated_a: assert property (ack_valid_reg |-> $past(global_irq_enable_reg))
		else $error("call while globally masked");
	ack_vector_a: assert property (ack_valid_reg |->
		vector_reg inside {11'h004, 11'h008, 11'h00C})
		else $error("call to unknown vector");
	ack_no_ret_a: assert property (ack_valid_reg |->
		!$past(subroutine_return) && !$past(return_and_unmask))
		else $error("call taken with a pop");
	unmask_ret_a: assert property (return_and_unmask |=>
		ret_valid_reg && global_irq_enable_reg)
		else $error("unmasking return failed");
	plain_ret_a: assert property (plain_ret |=> ret_valid_reg &&
		global_irq_enable_reg == $past(global_irq_enable_reg))
		else $error("plain return moved the enable");
endmodule // tsic_chk
bind tsic_irq_ctrl tsic_chk chk (.pclk, .presetn, .psel, .penable,
	.pready_reg, .second_clock_phase, .subroutine_return,
	.return_and_unmask, .ack_valid_reg, .vector_reg, .ret_valid_reg,
	.global_irq_enable_reg);
`default_nettype wire

// file: test/tsic_cpu_model.sv
// sequencer and timer source model driving the irq control
`timescale 1ns/1ns
`default_nettype none
module tsic_cpu_model (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	output logic second_clock_phase, // sampling pulse
	output logic [5:0] pulses, // unmask ret, ret, call, b, a, tick
	output logic [10:0] pc_in // running program counter
);
	logic [1:0] phase_cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_cnt <= 2'h0;
			pc_in <= 11'h100;
			second_clock_phase <= 1'b0;
		end else begin
			phase_cnt <= phase_cnt + 2'h1;
			pc_in <= pc_in + 11'h001;
			second_clock_phase <= (phase_cnt == 2'h3);
		end
	end
	// one-cycle pulses only, as the sources give them
	task automatic fire(input logic [5:0] which);
		@(posedge pclk);
		pulses <= which;
		@(posedge pclk);
		pulses <= 6'h00;
	endtask
	initial pulses = 6'h00;
endmodule // tsic_cpu_model
`default_nettype wire

// file: test/tb_three_source_irq_control.sv
// self-checking bench for the three-source irq control
`timescale 1ns/1ns
`default_nettype none
`include "tsic_regs.vh"
module tb_three_source_irq_control;
	logic pclk, presetn, psel, penable, pwrite, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] pc_in, vector, ret_pc, s1, s2, s3;
	logic pready, pslverr, phase, ack, ret_v, gie, irq;
	logic [5:0] p;
	int mismatches, checked;
	tsic_irq_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata_reg(prdata), .pready_reg(pready),
		.pslverr_reg(pslverr), .second_clock_phase(phase),
		.tick_event(p[0]), .timer_a_ovf(p[1]), .timer_b_ovf(p[2]),
		.call_req(p[3]), .subroutine_return(p[4]), .return_and_unmask(p[5]),
		.pc_in(pc_in), .ack_valid_reg(ack), .vector_reg(vector),
		.ret_valid_reg(ret_v), .ret_pc_reg(ret_pc),
		.global_irq_enable_reg(gie), .irq_reg(irq));
	tsic_cpu_model cpu (.pclk(pclk), .presetn(presetn),
		.second_clock_phase(phase), .pulses(p), .pc_in(pc_in));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [5:0] idx,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask
	// pushed value is the program counter one cycle before the call shows
	task automatic wack(input logic [10:0] v, output logic [10:0] pushed);
		for (int n = 0; n < 40 && ack !== 1'b1; n++) @(negedge pclk);
		pushed = pc_in - 11'h001;
		chk({ack, vector}, {1'b1, v});
	endtask
	task automatic pop(input logic [5:0] kind, input logic [10:0] exp);
		cpu.fire(kind);
		@(negedge pclk);
		chk({ret_v, ret_pc}, {1'b1, exp});
	endtask
	task automatic noack;
		repeat (12) begin
			@(negedge pclk);
			chk(ack, 1'b0);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		mismatches = 0;
		checked = 0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(`TSIC_IDX_CONTROL, 32'h00);
		rdchk(`TSIC_IDX_STACK, 32'h00);
		xfer(1'b0, 6'h00, 32'h0);
		chk(err, 1'b1);
		xfer(1'b1, `TSIC_IDX_STACK, 32'h0);
		chk(err, 1'b1);
		xfer(1'b1, `TSIC_IDX_EVMASK, 32'h01);
		$display("test registers done");
		xfer(1'b1, `TSIC_IDX_CONTROL, 32'h0E);
		cpu.fire(6'h07);
		noack();
		rdchk(`TSIC_IDX_CONTROL, 32'h7E);
		xfer(1'b1, `TSIC_IDX_CONTROL, 32'h7F);
		wack(`TSIC_VEC_TICK, s1);
		rdchk(`TSIC_IDX_CONTROL, 32'h6E);
		xfer(1'b1, `TSIC_IDX_CONTROL, 32'h6F);
		wack(`TSIC_VEC_TA, s2);
		pop(6'h20, s2);
		wack(`TSIC_VEC_TB, s3);
		pop(6'h10, s3);
		chk(gie, 1'b0);
		rdchk(`TSIC_IDX_CONTROL, 32'h0E);
		pop(6'h10, s1);
		$display("test service done");
		repeat (4) cpu.fire(6'h08);
		rdchk(`TSIC_IDX_STACK, 32'h0C);
		chk(irq, 1'b1);
		rdchk(`TSIC_IDX_EVENTS, 32'h01);
		xfer(1'b1, `TSIC_IDX_CONTROL, 32'h03);
		cpu.fire(6'h01);
		noack();
		chk(irq, 1'b0);
		rdchk(`TSIC_IDX_EVENTS, 32'h02);
		cpu.fire(6'h10);
		wack(`TSIC_VEC_TICK, s1);
		cpu.fire(6'h08);
		rdchk(`TSIC_IDX_STACK, 32'h0C);
		xfer(1'b0, `TSIC_IDX_EVENTS, 32'h0);
		chk(rd[`TSIC_EV_OVERFLOW], 1'b1);
		$display("test stack full done");
		end_sim();
	end
endmodule // tb_three_source_irq_control
`default_nettype wire
